// File: sffm_params.svh
/*
 * Constants of the 18-bit FIFO bank: widths, depths, offset defaults,
 * strap code and register offsets.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SFFM_PARAMS_SVH
`define SFFM_PARAMS_SVH

// Data path and pointers
`define SFFM_DW 18
`define SFFM_AW 12
`define SFFM_PW 13
`define SFFM_OW 12
`define SFFM_MEM_WORDS 4096
`define SFFM_PTR_ZERO 13'h0000
`define SFFM_PTR_ONE 13'h0001

// Depth choices in words
`define SFFM_DEPTH_256 13'h0100
`define SFFM_DEPTH_512 13'h0200
`define SFFM_DEPTH_1024 13'h0400
`define SFFM_DEPTH_4096 13'h1000

// Offset defaults when nothing was loaded
`define SFFM_AE_DEF_256 12'h01F
`define SFFM_AE_DEF_512 12'h01F
`define SFFM_AE_DEF_BIG 12'h03F
`define SFFM_AF_DEF_256 12'h01F
`define SFFM_AF_DEF_512 12'h03F
`define SFFM_AF_DEF_BIG 12'h07F

// Strap {first_load_n, read_expansion_in_n, write_expansion_in_n} for fall-through
`define SFFM_STRAP_FALL_THROUGH 3'h1

// APB register byte offsets and reset values
`define SFFM_APB_AW 12
`define SFFM_REG_CTRL 12'h000
`define SFFM_REG_STATUS 12'h004
`define SFFM_REG_EMPTY_OFS 12'h008
`define SFFM_REG_FULL_OFS 12'h00C
`define SFFM_REG_LEVEL 12'h010
`define SFFM_CTRL_RST 2'h0
`define SFFM_OFS_RST 12'h000
`define SFFM_DATA_RST 18'h00000
`define SFFM_WORD_ZERO 32'h00000000

`endif

// File: sffm_pkg.sv
/*
 * Types shared by the FIFO bank modules.
 * Assumes sffm_params.svh is on the include path.
 */
`include "sffm_params.svh"

package sffm_pkg;
    typedef enum logic [1:0] {DEPTH_256, DEPTH_512, DEPTH_1024, DEPTH_4096} sffm_depth_t;
    typedef enum logic {MODE_STANDARD, MODE_FALL_THROUGH} sffm_mode_t;
    typedef enum logic {LOAD_EMPTY_OFS, LOAD_FULL_OFS} sffm_load_t;
    typedef logic [`SFFM_PW-1:0] sffm_ptr_t;
endpackage

// File: sffm_ptr_sync.sv
/*
 * Pointer carrier: gray-codes a pointer, passes it through two flops and
 * decodes it back to binary on the far side.
 * Assumes one clock; the delay keeps the far side's view conservative.
 */
`timescale 1ns/100ps
`default_nettype none

`include "sffm_params.svh"

module sffm_ptr_sync
    import sffm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pointer in and delayed view out
    input wire sffm_ptr_t ptr_in,
    output sffm_ptr_t ptr_out
);

    sffm_ptr_t gray_src;
    sffm_ptr_t meta_ff;
    sffm_ptr_t sync_ff;

    assign gray_src = ptr_in ^ (ptr_in >> 1);

    // Only one bit changes per step, so a torn sample is never seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= `SFFM_PTR_ZERO;
            sync_ff <= `SFFM_PTR_ZERO;
        end else begin
            meta_ff <= gray_src;
            sync_ff <= meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign ptr_out[`SFFM_PW-1] = sync_ff[`SFFM_PW-1];
    genvar gi;
    generate
        for (gi = `SFFM_PW - 2; gi >= 0; gi = gi - 1) begin : g_gray2bin
            assign ptr_out[gi] = ptr_out[gi+1] ^ sync_ff[gi];
        end
    endgenerate

endmodule // sffm_ptr_sync

`default_nettype wire

// File: sffm_fifo.sv
/*
 * One 18-bit FIFO bank with standard and first-word-fall-through reads,
 * active-low status flags, offset loading and an APB register slave.
 * Assumes write and read ports are synchronous to clk and that reset_n is
 * held low for at least three clocks.
 */
`timescale 1ns/100ps
`default_nettype none

`include "sffm_params.svh"

// Summary of operation
// - Mode straps sampled while reset_n low
// - Standard mode: output changes only on read
// - Read enable at edge loads next word
// - Fall-through: first word after three edges
// - Write enable low stores input word
// - Empty flag rises after first write
// - Almost-empty rises at n+1 words
// - Half-full falls at depth/2 plus one
// - Almost-full falls at depth minus m
// - Default full offset 31, 63 or 127
// - Full flag at depth; writes ignored
// - First read from full clears full
// - Almost-full, half-full rise below thresholds
// - Almost-empty low at n or fewer
// - Default empty offset 31 or 63
// - Last read drops empty, blocks reads
// - Read enable ignored while empty
// - Load pin alternates empty/full offset writes
// - Partial flags update on own port edge
module sffm_fifo
    import sffm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Device reset and configuration straps
    input wire logic reset_n,
    input wire logic first_load_n,
    input wire logic read_expansion_in_n,
    input wire logic write_expansion_in_n,
    // Write port
    input wire logic write_enable_n,
    input wire logic offset_load_n,
    input wire logic [`SFFM_DW-1:0] data_in,
    // Read port
    input wire logic read_enable_n,
    output logic [`SFFM_DW-1:0] data_out,
    // Status flags
    output logic empty_flag_n,
    output logic almost_empty_flag_n,
    output logic half_full_flag_n,
    output logic almost_full_flag_n,
    output logic full_flag_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SFFM_APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic sffm_ptr_t depth_words(input sffm_depth_t sel);
        case (sel)
            DEPTH_256: depth_words = `SFFM_DEPTH_256;
            DEPTH_512: depth_words = `SFFM_DEPTH_512;
            DEPTH_1024: depth_words = `SFFM_DEPTH_1024;
            default: depth_words = `SFFM_DEPTH_4096;
        endcase
    endfunction

    function automatic logic [`SFFM_OW-1:0] ofs_default(input sffm_depth_t sel,
                                                        input logic is_full);
        case (sel)
            DEPTH_256: ofs_default = is_full ? `SFFM_AF_DEF_256 : `SFFM_AE_DEF_256;
            DEPTH_512: ofs_default = is_full ? `SFFM_AF_DEF_512 : `SFFM_AE_DEF_512;
            default: ofs_default = is_full ? `SFFM_AF_DEF_BIG : `SFFM_AE_DEF_BIG;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [`SFFM_DW-1:0] mem [0:`SFFM_MEM_WORDS-1];
    sffm_ptr_t wptr_ff;
    sffm_ptr_t rptr_ff;
    sffm_ptr_t wptr_sync;
    sffm_ptr_t rptr_sync;
    sffm_mode_t mode_ff;
    sffm_depth_t depth_sel_ff;
    sffm_load_t load_state_ff;
    logic [`SFFM_OW-1:0] empty_ofs_ff;
    logic [`SFFM_OW-1:0] full_ofs_ff;
    logic empty_ofs_set_ff;
    logic full_ofs_set_ff;
    logic out_valid_ff;
    logic [`SFFM_DW-1:0] data_out_ff;
    logic empty_flag_n_ff;
    logic almost_empty_flag_n_ff;
    logic half_full_flag_n_ff;
    logic almost_full_flag_n_ff;
    logic full_flag_n_ff;
    logic pready_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Configuration
    wire in_reset = ~reset_n;
    wire [2:0] strap = {first_load_n, read_expansion_in_n, write_expansion_in_n};
    wire first_word_fall_through_mode = (mode_ff == MODE_FALL_THROUGH);
    wire sffm_ptr_t depth = depth_words(depth_sel_ff);
    wire [`SFFM_OW-1:0] empty_ofs = empty_ofs_set_ff ? empty_ofs_ff
                                                     : ofs_default(depth_sel_ff, 1'b0);
    wire [`SFFM_OW-1:0] full_ofs = full_ofs_set_ff ? full_ofs_ff
                                                   : ofs_default(depth_sel_ff, 1'b1);

    // Strap is caught by the clock, never by the async reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= MODE_STANDARD;
        end else if (in_reset) begin
            mode_ff <= (strap == `SFFM_STRAP_FALL_THROUGH) ? MODE_FALL_THROUGH
                                                            : MODE_STANDARD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer crossing, delayed views only ever lag the truth
    sffm_ptr_sync u_wptr_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ptr_in(wptr_ff),
        .ptr_out(wptr_sync)
    );

    sffm_ptr_sync u_rptr_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ptr_in(rptr_ff),
        .ptr_out(rptr_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write side
    wire wr_load = ~write_enable_n & ~offset_load_n & ~in_reset;
    wire wr_push = ~write_enable_n & offset_load_n & full_flag_n_ff & ~in_reset;
    wire sffm_ptr_t nxt_wptr = in_reset ? `SFFM_PTR_ZERO
                             : wr_push ? sffm_ptr_t'(wptr_ff + `SFFM_PTR_ONE) : wptr_ff;
    wire sffm_ptr_t occ_w = sffm_ptr_t'(nxt_wptr - rptr_sync);
    wire sffm_ptr_t af_level = sffm_ptr_t'(depth - {1'b0, full_ofs});
    wire nxt_full_flag_n = in_reset | (occ_w != depth);
    wire nxt_half_full_flag_n = in_reset | (occ_w <= (depth >> 1));
    wire nxt_almost_full_flag_n = in_reset | (occ_w < af_level);

    always_ff @(posedge clk) begin
        if (wr_push) begin
            mem[wptr_ff[`SFFM_AW-1:0]] <= data_in;
        end
    end

    // Flags of the write side follow the next write pointer and the delayed read pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_ff <= `SFFM_PTR_ZERO;
            full_flag_n_ff <= 1'b1;
            half_full_flag_n_ff <= 1'b1;
            almost_full_flag_n_ff <= 1'b1;
        end else begin
            wptr_ff <= nxt_wptr;
            full_flag_n_ff <= nxt_full_flag_n;
            half_full_flag_n_ff <= nxt_half_full_flag_n;
            almost_full_flag_n_ff <= nxt_almost_full_flag_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read side
    wire rd_avail = (wptr_sync != rptr_ff);
    wire rd_want = first_word_fall_through_mode ? (~out_valid_ff | ~read_enable_n)
                                                : ~read_enable_n;
    wire rd_pop = rd_want & rd_avail & ~in_reset;
    wire sffm_ptr_t nxt_rptr = in_reset ? `SFFM_PTR_ZERO
                             : rd_pop ? sffm_ptr_t'(rptr_ff + `SFFM_PTR_ONE) : rptr_ff;
    wire sffm_ptr_t occ_r = sffm_ptr_t'(wptr_sync - nxt_rptr);
    wire nxt_out_valid = first_word_fall_through_mode & ~in_reset
                       & (rd_pop | (out_valid_ff & read_enable_n));
    wire nxt_empty_flag_n = first_word_fall_through_mode ? nxt_out_valid
                          : (~in_reset & (occ_r != `SFFM_PTR_ZERO));
    wire nxt_almost_empty_flag_n = ~in_reset & (occ_r > {1'b0, empty_ofs});

    // Standard mode only loads the output on an explicit read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out_ff <= `SFFM_DATA_RST;
        end else if (rd_pop) begin
            data_out_ff <= mem[rptr_ff[`SFFM_AW-1:0]];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rptr_ff <= `SFFM_PTR_ZERO;
            out_valid_ff <= 1'b0;
            empty_flag_n_ff <= 1'b0;
            almost_empty_flag_n_ff <= 1'b0;
        end else begin
            rptr_ff <= nxt_rptr;
            out_valid_ff <= nxt_out_valid;
            empty_flag_n_ff <= nxt_empty_flag_n;
            almost_empty_flag_n_ff <= nxt_almost_empty_flag_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire apb_setup = psel & ~penable;
    wire sel_ctrl = (paddr == `SFFM_REG_CTRL);
    wire sel_status = (paddr == `SFFM_REG_STATUS);
    wire sel_eofs = (paddr == `SFFM_REG_EMPTY_OFS);
    wire sel_fofs = (paddr == `SFFM_REG_FULL_OFS);
    wire sel_level = (paddr == `SFFM_REG_LEVEL);
    wire addr_ok = sel_ctrl | sel_status | sel_eofs | sel_fofs | sel_level;
    wire apb_wr = psel & penable & pready_ff & pwrite & addr_ok;
    wire sffm_ptr_t level_now = sffm_ptr_t'(wptr_ff - rptr_sync);
    wire [7:0] status_bits = {in_reset, out_valid_ff, first_word_fall_through_mode,
                              full_flag_n_ff, almost_full_flag_n_ff, half_full_flag_n_ff,
                              almost_empty_flag_n_ff, empty_flag_n_ff};
    logic [31:0] rd_mux;

    always_comb begin
        if (sel_ctrl) begin
            rd_mux = {30'h00000000, depth_sel_ff};
        end else if (sel_status) begin
            rd_mux = {24'h000000, status_bits};
        end else if (sel_eofs) begin
            rd_mux = {20'h00000, empty_ofs};
        end else if (sel_fofs) begin
            rd_mux = {20'h00000, full_ofs};
        end else if (sel_level) begin
            rd_mux = {19'h00000, level_now};
        end else begin
            rd_mux = `SFFM_WORD_ZERO;
        end
    end

    // Answer is prepared in the setup cycle, so every access has no wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            prdata_ff <= `SFFM_WORD_ZERO;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= apb_setup;
            prdata_ff <= (apb_setup & ~pwrite) ? rd_mux : `SFFM_WORD_ZERO;
            pslverr_ff <= apb_setup & ~addr_ok;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            depth_sel_ff <= sffm_depth_t'(`SFFM_CTRL_RST);
        end else if (apb_wr & sel_ctrl) begin
            depth_sel_ff <= sffm_depth_t'(pwdata[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Offset registers; the load pin wins over a same-cycle APB write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_state_ff <= LOAD_EMPTY_OFS;
            empty_ofs_ff <= `SFFM_OFS_RST;
            full_ofs_ff <= `SFFM_OFS_RST;
            empty_ofs_set_ff <= 1'b0;
            full_ofs_set_ff <= 1'b0;
        end else if (in_reset) begin
            load_state_ff <= LOAD_EMPTY_OFS;
            empty_ofs_set_ff <= 1'b0;
            full_ofs_set_ff <= 1'b0;
        end else if (wr_load) begin
            case (load_state_ff)
                LOAD_EMPTY_OFS: begin
                    empty_ofs_ff <= data_in[`SFFM_OW-1:0];
                    empty_ofs_set_ff <= 1'b1;
                    load_state_ff <= LOAD_FULL_OFS;
                end
                default: begin
                    full_ofs_ff <= data_in[`SFFM_OW-1:0];
                    full_ofs_set_ff <= 1'b1;
                    load_state_ff <= LOAD_EMPTY_OFS;
                end
            endcase
        end else if (apb_wr & sel_eofs) begin
            empty_ofs_ff <= pwdata[`SFFM_OW-1:0];
            empty_ofs_set_ff <= 1'b1;
        end else if (apb_wr & sel_fofs) begin
            full_ofs_ff <= pwdata[`SFFM_OW-1:0];
            full_ofs_set_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign data_out = data_out_ff;
    assign empty_flag_n = empty_flag_n_ff;
    assign almost_empty_flag_n = almost_empty_flag_n_ff;
    assign half_full_flag_n = half_full_flag_n_ff;
    assign almost_full_flag_n = almost_full_flag_n_ff;
    assign full_flag_n = full_flag_n_ff;
    assign pready = pready_ff;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;

endmodule // sffm_fifo

`default_nettype wire

// File: sffm_fifo_chk.sv
/*
 * Assertion checker for sffm_fifo: flag relations and the causes of flag moves.
 * Assumes it is bound to sffm_fifo and sees only that module's ports.
 */
`timescale 1ns/100ps
`default_nettype none

`include "sffm_params.svh"

module sffm_fifo_chk (
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reset_n,
    // Straps and port controls
    input wire logic first_load_n,
    input wire logic read_expansion_in_n,
    input wire logic write_expansion_in_n,
    input wire logic write_enable_n,
    input wire logic read_enable_n,
    // Outputs
    input wire logic [`SFFM_DW-1:0] data_out,
    input wire logic empty_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic half_full_flag_n,
    input wire logic almost_full_flag_n,
    input wire logic full_flag_n
);
    ////////////////////////////////////////////////////////////////////////
    // Ages saturate at 7 so an old event never meets a bound
    logic thru_ff;
    logic [2:0] rd_age_ff;
    logic [2:0] wr_age_ff;
    wire logic strap_thru =
        {first_load_n, read_expansion_in_n, write_expansion_in_n} == `SFFM_STRAP_FALL_THROUGH;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thru_ff <= 1'b0;
            rd_age_ff <= 3'h0;
            wr_age_ff <= 3'h0;
        end else begin
            thru_ff <= reset_n ? thru_ff : strap_thru;
            rd_age_ff <= (!reset_n || !read_enable_n) ? 3'h0 : rd_age_ff + 3'(rd_age_ff != 3'h7);
            wr_age_ff <= !write_enable_n ? 3'h0 : wr_age_ff + 3'(wr_age_ff != 3'h7);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    reset_flags_a: assert property (
        !reset_n |=> !empty_flag_n && !almost_empty_flag_n && half_full_flag_n
        && almost_full_flag_n && full_flag_n) else $error("reset flag levels wrong");
    full_flags_a: assert property (
        !full_flag_n |-> !almost_full_flag_n && !half_full_flag_n) else $error("full alone");
    full_hold_a: assert property (
        (reset_n && read_enable_n)[*5] ##0 (!full_flag_n && !thru_ff) |=> !full_flag_n)
        else $error("full lost with no read");
    std_out_a: assert property (
        !thru_ff && $changed(data_out) |-> !$past(read_enable_n)) else $error("output moved");
    ae_implies_a: assert property (
        !thru_ff && almost_empty_flag_n |-> empty_flag_n) else $error("almost-empty above empty");
    empty_rise_a: assert property (
        $rose(empty_flag_n) |-> wr_age_ff <= 3'h5) else $error("data flag rose with no write");
    read_fall_a: assert property (
        !thru_ff && ($fell(empty_flag_n) || $fell(almost_empty_flag_n)) |-> rd_age_ff <= 3'h1)
        else $error("read-side flag fell with no read");
    write_fall_a: assert property (
        $fell(full_flag_n) || $fell(half_full_flag_n) |-> wr_age_ff <= 3'h1)
        else $error("write-side flag fell with no write");
    read_rise_a: assert property (
        !thru_ff && ($rose(full_flag_n) || $rose(half_full_flag_n)) |-> rd_age_ff <= 3'h5)
        else $error("write-side flag rose with no read");
endmodule // sffm_fifo_chk

bind sffm_fifo sffm_fifo_chk chk_u (
    .clk(clk), .rst_n(rst_n), .reset_n(reset_n),
    .first_load_n(first_load_n), .read_expansion_in_n(read_expansion_in_n),
    .write_expansion_in_n(write_expansion_in_n), .write_enable_n(write_enable_n),
    .read_enable_n(read_enable_n), .data_out(data_out), .empty_flag_n(empty_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .half_full_flag_n(half_full_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .full_flag_n(full_flag_n)
);

`default_nettype wire

// File: sffm_peer.sv
/*
 * Producer and consumer logic on the write and read ports of the bank.
 * Assumes bench commands change just after a rising clk edge.
 */
`timescale 1ns/100ps
`default_nettype none

`include "sffm_params.svh"

module sffm_peer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench commands
    input wire logic wr_go,
    input wire logic rd_go,
    input wire logic [`SFFM_DW-1:0] wr_word,
    // FIFO side
    output logic write_enable_n,
    output logic read_enable_n,
    output logic [`SFFM_DW-1:0] data_in
);
    // Idle data toggles so a stale word is never stored by accident
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_n <= 1'b1;
            read_enable_n <= 1'b1;
            data_in <= 18'h00000;
        end else begin
            write_enable_n <= !wr_go;
            read_enable_n <= !rd_go;
            data_in <= wr_go ? wr_word : ~data_in;
        end
    end
endmodule // sffm_peer

`default_nettype wire

// File: tb_sffm_fifo.sv
/*
 * Bench for sffm_fifo: fill and drain passes with flag tracking, offset
 * loading, APB register access and a first-word-fall-through start.
 * Assumes the peer and the checker are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

`include "sffm_params.svh"

module tb_sffm_fifo;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reset_n = 1'b0;
    logic first_load_n = 1'b0, read_expansion_in_n = 1'b0, write_expansion_in_n = 1'b0;
    logic offset_load_n = 1'b1, wr_go = 1'b0, rd_go = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [17:0] wr_word = 18'h0, data_in, data_out;
    logic write_enable_n, read_enable_n, pready, pslverr;
    logic empty_flag_n, almost_empty_flag_n, half_full_flag_n, almost_full_flag_n, full_flag_n;
    wire [4:0] flg = {empty_flag_n, almost_empty_flag_n, half_full_flag_n,
        almost_full_flag_n, full_flag_n};
    int err_total = 0;
    int n_checks = 0;

    always #4 clk = ~clk;

    sffm_fifo dut_u (.clk(clk), .rst_n(rst_n), .reset_n(reset_n),
        .first_load_n(first_load_n), .read_expansion_in_n(read_expansion_in_n),
        .write_expansion_in_n(write_expansion_in_n), .write_enable_n(write_enable_n),
        .offset_load_n(offset_load_n), .data_in(data_in), .read_enable_n(read_enable_n),
        .data_out(data_out), .empty_flag_n(empty_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n), .half_full_flag_n(half_full_flag_n),
        .almost_full_flag_n(almost_full_flag_n), .full_flag_n(full_flag_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    sffm_peer peer_u (.clk(clk), .rst_n(rst_n), .wr_go(wr_go), .rd_go(rd_go),
        .wr_word(wr_word), .write_enable_n(write_enable_n),
        .read_enable_n(read_enable_n), .data_in(data_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [17:0] w);
        wr_go <= 1'b1;
        wr_word <= w;
        @(posedge clk);
        wr_go <= 1'b0;
    endtask

    task automatic rd1();
        rd_go <= 1'b1;
        @(posedge clk);
        rd_go <= 1'b0;
    endtask

    // Zero wait states are expected, but the loop does not rely on it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] exp, input logic se);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            err_total++;
            close_out();
        end
        if (!w) chk(prdata, exp);
        chk({31'h0, pslverr}, {31'h0, se});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Flags for a settled count c with offsets n and m, 256-word depth
    function automatic logic [4:0] expf(input int c, input int n, input int m);
        return {c > 0, c > n, c < 129, c < 256 - m, c < 256};
    endfunction

    task automatic pass(input int n, input int m, input logic [17:0] base, input logic [17:0] q0);
        int k;
        for (k = 1; k <= 256; k++) begin
            wr(base + 18'(k));
            tick(5);
            chk(data_out, q0);
            chk(flg, expf(k, n, m));
        end
        wr(18'h3FFFF);
        tick(5);
        chk(flg, expf(256, n, m));
        for (k = 1; k <= 256; k++) begin
            rd1();
            tick(5);
            chk(data_out, base + 18'(k));
            chk(flg, expf(256 - k, n, m));
        end
        rd1();
        tick(5);
        chk(data_out, base + 18'h100);
        chk(flg, expf(0, n, m));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        rst_n <= 1'b1;
        tick(3);
        reset_n <= 1'b1;
        tick(2);
        chk(flg, 5'h07);
        apb(1'b0, `SFFM_REG_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, `SFFM_REG_EMPTY_OFS, 32'h0, 32'h1F, 1'b0);
        apb(1'b0, `SFFM_REG_FULL_OFS, 32'h0, 32'h1F, 1'b0);
        apb(1'b1, 12'h020, 32'h0000FFFF, 32'h0, 1'b1);
        apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
        pass(32'h1F, 32'h1F, 18'h01000, 18'h00000);
        offset_load_n <= 1'b0;
        wr(18'h00005);
        tick(2);
        offset_load_n <= 1'b1;
        tick(3);
        offset_load_n <= 1'b0;
        wr(18'h0000A);
        tick(2);
        offset_load_n <= 1'b1;
        tick(1);
        apb(1'b0, `SFFM_REG_EMPTY_OFS, 32'h0, 32'h5, 1'b0);
        apb(1'b0, `SFFM_REG_FULL_OFS, 32'h0, 32'hA, 1'b0);
        pass(32'h5, 32'hA, 18'h22000, 18'h01100);
        apb(1'b1, `SFFM_REG_FULL_OFS, 32'h00000080, 32'h0, 1'b0);
        apb(1'b0, `SFFM_REG_FULL_OFS, 32'h0, 32'h80, 1'b0);
        apb(1'b1, `SFFM_REG_LEVEL, 32'h00000055, 32'h0, 1'b0);
        apb(1'b0, `SFFM_REG_LEVEL, 32'h0, 32'h0, 1'b0);
        // Straps are only looked at while the device reset is low
        reset_n <= 1'b0;
        write_expansion_in_n <= 1'b1;
        tick(4);
        // Depth is rewritten here while the device reset is low; defaults follow it
        apb(1'b1, `SFFM_REG_CTRL, 32'h00000002, 32'h0, 1'b0);
        apb(1'b0, `SFFM_REG_CTRL, 32'h0, 32'h2, 1'b0);
        apb(1'b0, `SFFM_REG_EMPTY_OFS, 32'h0, 32'h3F, 1'b0);
        apb(1'b0, `SFFM_REG_FULL_OFS, 32'h0, 32'h7F, 1'b0);
        apb(1'b1, `SFFM_REG_CTRL, 32'h00000001, 32'h0, 1'b0);
        apb(1'b0, `SFFM_REG_FULL_OFS, 32'h0, 32'h3F, 1'b0);
        apb(1'b0, `SFFM_REG_STATUS, 32'h0, 32'hBC, 1'b0);
        reset_n <= 1'b1;
        tick(2);
        chk(flg, 5'h07);
        wr(18'h2A5A5);
        tick(3);
        #1;
        chk(data_out, 32'h22100);
        @(posedge clk);
        #1;
        chk(data_out, 32'h2A5A5);
        chk(flg, 5'h17);
        close_out();
    end
endmodule // tb_sffm_fifo

`default_nettype wire
